// File: shared/tsr_pkg.sv
// constants and helpers shared by the touch status and error registers
package tsr_pkg;
	typedef logic [7:0] tsr_byte_t;

	// host-visible register addresses
	localparam tsr_byte_t ERR_REG_ADDR = 8'h01;
	localparam tsr_byte_t STS_REG_ADDR = 8'h02;
	localparam tsr_byte_t SRATE_REG_ADDR = 8'h21;
	localparam tsr_byte_t MAP_TOP_ADDR = 8'h70;

	// error register field positions
	localparam int ERR_BAUD = 7;
	localparam int ERR_CAL = 6;
	localparam int ERR_SRATE = 5;
	localparam int ERR_RO = 4;
	localparam int ERR_CNT = 3;
	localparam int ERR_ADR = 2;
	localparam int ERR_EOF = 1;
	localparam int ERR_PAR = 0;

	// status register field positions
	localparam int STS_TOUCH = 7;
	localparam int STS_DUAL = 6;
	localparam int STS_ZOOM = 5;
	localparam int STS_ROT = 4;
	localparam int STS_SLIDE = 3;
	localparam int STS_FIFO = 2;
	localparam int STS_CAP = 1;
	localparam int STS_RDY = 0;

	// reset values and masks
	localparam tsr_byte_t ERR_RST = 8'h00;
	localparam tsr_byte_t STS_RST = 8'h00;
	localparam tsr_byte_t LATCH_MASK = 8'h3B;

	// legal ranges
	localparam tsr_byte_t SRATE_MIN = 8'h05;
	localparam tsr_byte_t SRATE_MAX = 8'h64;
	localparam tsr_byte_t CNT_MIN = 8'h01;
	localparam tsr_byte_t CNT_MAX = 8'h65;

	// true when v lies within lo..hi inclusive
	function automatic logic in_range(tsr_byte_t v, tsr_byte_t lo,
		tsr_byte_t hi);
		return (v >= lo) && (v <= hi);
	endfunction
endpackage

// File: shared/tsr_flag_if.sv
// set, clear and value of one clear-on-read flag bank
`timescale 1ns/1ps
interface tsr_flag_if;
	logic [7:0] set;
	logic [7:0] clr;
	logic [7:0] q;
	modport bank(input set, input clr, output q);
	modport user(output set, output clr, input q);
endinterface

// File: rtl/tsr_sticky.sv
// sticky flag bank where a new event beats a clearing read
`timescale 1ns/1ps
module tsr_sticky #(
	parameter tsr_pkg::tsr_byte_t RST_VAL = 8'h00
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// flag bank
	tsr_flag_if.bank f
);
	import tsr_pkg::*;

	logic [7:0] flags_q;
	logic [7:0] flags_d;

	// R22 set wins
	assign flags_d = (flags_q & ~f.clr) | f.set;

	// flag storage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags_q <= RST_VAL;
		end else begin
			flags_q <= flags_d;
		end
	end

	assign f.q = flags_q;

	a_set_beats_clear: assert property ( // R22
		@(posedge clk) disable iff (rst)
		(f.set != 8'h00) |=> ((f.q & $past(f.set)) == $past(f.set))
	) else $error("event lost against a clear");
endmodule

// File: rtl/tsr_req_check.sv
// checks host requests and frames for the error events they raise
`timescale 1ns/1ps
module tsr_req_check (
	// host request
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [7:0] req_addr,
	input wire logic [7:0] req_wdata,
	input wire logic req_unimpl,
	input wire logic req_ro_hit,
	// frame end
	input wire logic frame_end,
	input wire logic [7:0] frame_count,
	// results
	output logic own_hit,
	output logic ro_write,
	output logic srate_bad,
	output logic addr_bad,
	output logic count_bad
);
	import tsr_pkg::*;

	// request targets one of the two status registers
	assign own_hit = (req_addr == ERR_REG_ADDR) ||
		(req_addr == STS_REG_ADDR);

	// R1 refuse status writes
	assign ro_write = req_valid && req_write && (own_hit || req_ro_hit);

	// R5 sampling rate range
	assign srate_bad = req_valid && req_write &&
		(req_addr == SRATE_REG_ADDR) &&
		!in_range(req_wdata, SRATE_MIN, SRATE_MAX);

	// R8 address outside map
	assign addr_bad = req_valid &&
		((req_addr > MAP_TOP_ADDR) || req_unimpl);

	// R7 data count range
	assign count_bad = frame_end &&
		!in_range(frame_count, CNT_MIN, CNT_MAX);
endmodule

// File: rtl/tsr_regs.sv
// error and event status registers of the touch controller
`timescale 1ns/1ps

// What this block does
// R1 - status registers read-only; host writes get an invalid-write answer
// R2 - reading the error register clears all its bits
// R3 - error bit 7 set when baud-rate detection fails
// R4 - error bit 6 set when calibration cannot compute its values
// R5 - error bit 5 set on sampling-rate write below 5 or above 100
// R6 - error bit 4 set on any write to a read-only address
// R7 - error bit 3 set when frame data count is 0 or above 101
// R8 - error bit 2 set when requested address is unmapped or unimplemented
// R9 - error bit 1 set when end of frame misses the timeout
// R10 - error bit 0 set when a received byte fails odd parity
// R11 - status event bits latch until the host reads the register
// R12 - reading status register 1 sets the host attention pin
// R13 - status bit 7 follows the live touched state
// R14 - status bit 6 follows the live two-touch condition
// R15 - status bit 5 latches a zoom gesture until read
// R16 - status bit 4 latches a rotate gesture until read
// R17 - status bit 3 latches a slide gesture until read
// R18 - status bit 2 high when FIFO reaches watermark or is full
// R19 - status bit 1 latches an enabled capacitive event until read
// R20 - status bit 0 latches a finished coordinate sample until read
// R21 - bits 0,1,3,4,5 clear on read; bits 2,6,7 are live
// R22 - an event in the same cycle as a clearing read stays set
module tsr_regs (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// host request
	input wire logic REQ_VALID,
	input wire logic REQ_WRITE,
	input wire logic [7:0] REQ_ADDR,
	input wire tsr_pkg::tsr_byte_t REQ_WDATA,
	input wire logic REQ_UNIMPL,
	input wire logic REQ_RO_HIT,
	// host answer
	output logic RSP_VALID,
	output tsr_pkg::tsr_byte_t RSP_RDATA,
	output logic RSP_REFUSED,
	// link events
	input wire logic BAUD_FAIL,
	input wire logic FRAME_END,
	input wire logic [7:0] FRAME_COUNT,
	input wire logic FRAME_TIMEOUT,
	input wire logic PARITY_FAIL,
	// touch engine events
	input wire logic CAL_FAIL,
	input wire logic TOUCH_ACTIVE,
	input wire logic DUAL_TOUCH_ACTIVE,
	input wire logic ZOOM_EVT,
	input wire logic ROTATE_EVT,
	input wire logic SLIDE_EVT,
	input wire logic [7:0] FIFO_COUNT,
	input wire logic [7:0] FIFO_WMRK,
	input wire logic FIFO_FULL,
	input wire logic CAP_EVT,
	input wire logic SAMPLE_DONE,
	// host attention pin
	input wire logic HOST_ATTN_CLR,
	output logic HOST_ATTN_PIN
);
	import tsr_pkg::*;

	////////////////////////////////////////////////////////////////////
	// request decode

	logic own_hit;
	logic ro_write;
	logic srate_bad;
	logic addr_bad;
	logic count_bad;
	logic rd_err;
	logic rd_sts;
	logic fifo_level;
	tsr_byte_t err_set;
	tsr_byte_t sts_set;
	tsr_byte_t sts_view;

	tsr_req_check u_check (
		.req_valid(REQ_VALID),
		.req_write(REQ_WRITE),
		.req_addr(REQ_ADDR),
		.req_wdata(REQ_WDATA),
		.req_unimpl(REQ_UNIMPL),
		.req_ro_hit(REQ_RO_HIT),
		.frame_end(FRAME_END),
		.frame_count(FRAME_COUNT),
		.own_hit(own_hit),
		.ro_write(ro_write),
		.srate_bad(srate_bad),
		.addr_bad(addr_bad),
		.count_bad(count_bad)
	);

	// reads of the two registers
	assign rd_err = REQ_VALID && !REQ_WRITE && (REQ_ADDR == ERR_REG_ADDR);
	assign rd_sts = REQ_VALID && !REQ_WRITE && (REQ_ADDR == STS_REG_ADDR);

	////////////////////////////////////////////////////////////////////
	// error register

	tsr_flag_if err_if ();

	// error event sources
	always_comb begin
		err_set = 8'h00;
		// R3 baud detect fail
		err_set[ERR_BAUD] = BAUD_FAIL;
		// R4 calibration fail
		err_set[ERR_CAL] = CAL_FAIL;
		// R5 sampling rate range
		err_set[ERR_SRATE] = srate_bad;
		// R6 read-only write
		err_set[ERR_RO] = ro_write;
		// R7 data count range
		err_set[ERR_CNT] = count_bad;
		// R8 address range error
		err_set[ERR_ADR] = addr_bad;
		// R9 frame end timeout
		err_set[ERR_EOF] = FRAME_TIMEOUT;
		// R10 odd parity failure
		err_set[ERR_PAR] = PARITY_FAIL;
	end

	assign err_if.set = err_set;
	// R2 clear on read
	assign err_if.clr = {8{rd_err}};

	tsr_sticky #(
		.RST_VAL(ERR_RST)
	) u_err (
		.clk(CLK_SYS),
		.rst(RST),
		.f(err_if.bank)
	);

	////////////////////////////////////////////////////////////////////
	// status register 1

	tsr_flag_if sts_if ();

	// R18 fifo watermark or full
	assign fifo_level = FIFO_FULL || (FIFO_COUNT >= FIFO_WMRK);

	// latched event sources
	always_comb begin
		sts_set = 8'h00;
		// R15 zoom latch
		sts_set[STS_ZOOM] = ZOOM_EVT;
		// R16 rotate latch
		sts_set[STS_ROT] = ROTATE_EVT;
		// R17 slide latch
		sts_set[STS_SLIDE] = SLIDE_EVT;
		// R19 capacitive latch
		sts_set[STS_CAP] = CAP_EVT;
		// R20 sample ready latch
		sts_set[STS_RDY] = SAMPLE_DONE;
	end

	// R21 only latched bits stored
	assign sts_if.set = sts_set & LATCH_MASK;
	// R11 clear latched on read
	assign sts_if.clr = {8{rd_sts}} & LATCH_MASK;

	tsr_sticky #(
		.RST_VAL(STS_RST)
	) u_sts (
		.clk(CLK_SYS),
		.rst(RST),
		.f(sts_if.bank)
	);

	// live bits merged with latched ones
	always_comb begin
		sts_view = sts_if.q & LATCH_MASK;
		// R13 live touch
		sts_view[STS_TOUCH] = TOUCH_ACTIVE;
		// R14 live two-touch
		sts_view[STS_DUAL] = DUAL_TOUCH_ACTIVE;
		sts_view[STS_FIFO] = fifo_level;
	end

	////////////////////////////////////////////////////////////////////
	// host answer

	// answer flag, one cycle after each request
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			RSP_VALID <= 1'b0;
		end else begin
			RSP_VALID <= REQ_VALID;
		end
	end

	// R1 invalid write answer
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			RSP_REFUSED <= 1'b0;
		end else begin
			RSP_REFUSED <= ro_write;
		end
	end

	// read data taken before the clear lands
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			RSP_RDATA <= 8'h00;
		end else if (rd_err) begin
			RSP_RDATA <= err_if.q;
		end else if (rd_sts) begin
			RSP_RDATA <= sts_view;
		end else begin
			RSP_RDATA <= 8'h00;
		end
	end

	// R12 attention set on read
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			HOST_ATTN_PIN <= 1'b0;
		end else if (rd_sts) begin
			HOST_ATTN_PIN <= 1'b1;
		end else if (HOST_ATTN_CLR) begin
			HOST_ATTN_PIN <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks

	a_refuse_status_wr: assert property ( // R1
		@(posedge CLK_SYS) disable iff (RST)
		(REQ_VALID && REQ_WRITE && own_hit)
		|=> (RSP_VALID && RSP_REFUSED)
	) else $error("status write not refused");

	a_read_no_refuse: assert property ( // R1
		@(posedge CLK_SYS) disable iff (RST)
		(REQ_VALID && !REQ_WRITE) |=> !RSP_REFUSED
	) else $error("read answered as refused");

	a_err_read_clear: assert property ( // R2
		@(posedge CLK_SYS) disable iff (RST)
		(rd_err && err_set == 8'h00) |=> (err_if.q == 8'h00)
	) else $error("error register not cleared by read");

	a_err_read_data: assert property ( // R2
		@(posedge CLK_SYS) disable iff (RST)
		rd_err |=> (RSP_RDATA == $past(err_if.q))
	) else $error("error read returned wrong value");

	a_baud_err: assert property ( // R3
		@(posedge CLK_SYS) disable iff (RST)
		BAUD_FAIL |=> err_if.q[7]
	) else $error("baud failure not flagged");

	a_cal_err: assert property ( // R4
		@(posedge CLK_SYS) disable iff (RST)
		CAL_FAIL |=> err_if.q[6]
	) else $error("calibration failure not flagged");

	a_srate_low: assert property ( // R5
		@(posedge CLK_SYS) disable iff (RST)
		(REQ_VALID && REQ_WRITE && REQ_ADDR == SRATE_REG_ADDR &&
		REQ_WDATA < 8'h05) |=> err_if.q[5]
	) else $error("low sampling rate not flagged");

	a_srate_ok: assert property ( // R5
		@(posedge CLK_SYS) disable iff (RST)
		(REQ_WDATA >= 8'h05 && REQ_WDATA <= 8'h64) |-> !srate_bad
	) else $error("legal sampling rate flagged");

	a_ro_write_err: assert property ( // R6
		@(posedge CLK_SYS) disable iff (RST)
		(REQ_VALID && REQ_WRITE && REQ_RO_HIT) |=> err_if.q[4]
	) else $error("read-only write not flagged");

	a_count_err: assert property ( // R7
		@(posedge CLK_SYS) disable iff (RST)
		(FRAME_END && (FRAME_COUNT == 8'h00 || FRAME_COUNT > 8'h65))
		|=> err_if.q[3]
	) else $error("bad data count not flagged");

	a_count_ok: assert property ( // R7
		@(posedge CLK_SYS) disable iff (RST)
		(FRAME_COUNT == 8'h65) |-> !count_bad
	) else $error("count of 101 flagged");

	a_addr_err: assert property ( // R8
		@(posedge CLK_SYS) disable iff (RST)
		(REQ_VALID && REQ_ADDR > 8'h70) |=> err_if.q[2]
	) else $error("out of map address not flagged");

	a_eof_err: assert property ( // R9
		@(posedge CLK_SYS) disable iff (RST)
		FRAME_TIMEOUT |=> err_if.q[1]
	) else $error("frame end timeout not flagged");

	a_parity_err: assert property ( // R10
		@(posedge CLK_SYS) disable iff (RST)
		PARITY_FAIL |=> err_if.q[0]
	) else $error("parity failure not flagged");

	a_sts_latch_hold: assert property ( // R11
		@(posedge CLK_SYS) disable iff (RST)
		(sts_if.q[STS_RDY] && !rd_sts) |=> sts_if.q[STS_RDY]
	) else $error("latched sample flag lost before read");

	a_sts_read_clear: assert property ( // R11
		@(posedge CLK_SYS) disable iff (RST)
		(rd_sts && sts_set == 8'h00) |=> ((sts_if.q & 8'h3B) == 8'h00)
	) else $error("latched status not cleared by read");

	a_attn_on_read: assert property ( // R12
		@(posedge CLK_SYS) disable iff (RST)
		rd_sts |=> (HOST_ATTN_PIN && RSP_VALID)
	) else $error("attention pin not set by status read");

	a_touch_live: assert property ( // R13
		@(posedge CLK_SYS) disable iff (RST)
		rd_sts |=> (RSP_RDATA[7] == $past(TOUCH_ACTIVE))
	) else $error("touch bit does not follow screen");

	a_dual_live: assert property ( // R14
		@(posedge CLK_SYS) disable iff (RST)
		rd_sts |=> (RSP_RDATA[6] == $past(DUAL_TOUCH_ACTIVE))
	) else $error("two-touch bit does not follow screen");

	a_zoom_latch: assert property ( // R15
		@(posedge CLK_SYS) disable iff (RST)
		ZOOM_EVT ##1 (!rd_sts && !ZOOM_EVT) [*2] |=> sts_if.q[5]
	) else $error("zoom event not held");

	a_rotate_latch: assert property ( // R16
		@(posedge CLK_SYS) disable iff (RST)
		ROTATE_EVT |=> sts_if.q[4]
	) else $error("rotate event not latched");

	a_slide_latch: assert property ( // R17
		@(posedge CLK_SYS) disable iff (RST)
		SLIDE_EVT |=> sts_if.q[3]
	) else $error("slide event not latched");

	a_fifo_level: assert property ( // R18
		@(posedge CLK_SYS) disable iff (RST)
		(rd_sts && (FIFO_FULL || FIFO_COUNT >= FIFO_WMRK))
		|=> RSP_RDATA[2]
	) else $error("fifo level bit not reported");

	a_cap_latch: assert property ( // R19
		@(posedge CLK_SYS) disable iff (RST)
		CAP_EVT |=> sts_if.q[1]
	) else $error("capacitive event not latched");

	a_sample_latch: assert property ( // R20
		@(posedge CLK_SYS) disable iff (RST)
		SAMPLE_DONE |=> sts_if.q[0]
	) else $error("sample ready not latched");

	a_live_not_stored: assert property ( // R21
		@(posedge CLK_SYS) disable iff (RST)
		(sts_if.q & 8'hC4) == 8'h00
	) else $error("live bit stored in latch bank");

	a_read_vs_event: assert property ( // R22
		@(posedge CLK_SYS) disable iff (RST)
		(rd_sts && SAMPLE_DONE) |=> sts_if.q[0]
	) else $error("sample event lost against read");
endmodule

// File: tb/tsr_host_model.sv
// host side model that issues register requests and takes answers
`timescale 1ns/1ps
module tsr_host_model (
	// clock
	input wire logic clk,
	// request
	output logic req_valid,
	output logic req_write,
	output tsr_pkg::tsr_byte_t req_addr,
	output tsr_pkg::tsr_byte_t req_wdata,
	// answer
	input wire logic rsp_valid,
	input wire tsr_pkg::tsr_byte_t rsp_rdata,
	input wire logic rsp_refused
);
	import tsr_pkg::*;

	// idle bus at time zero
	initial begin
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = 8'h00;
		req_wdata = 8'h00;
	end

	// one request pulse; the answer is taken one cycle after it
	task automatic xfer(input logic wr, input tsr_byte_t adr,
		input tsr_byte_t wd, output tsr_byte_t rd, output logic refused,
		output logic ok);
		@(posedge clk);
		req_valid <= 1'b1;
		req_write <= wr;
		req_addr <= adr;
		req_wdata <= wd;
		@(posedge clk);
		req_valid <= 1'b0;
		// released bus must not keep showing the last value
		req_addr <= ~adr;
		req_wdata <= ~wd;
		// answer taken at the edge where it stands
		@(posedge clk);
		ok = rsp_valid;
		rd = rsp_rdata;
		refused = rsp_refused;
	endtask
endmodule

// File: tb/tsr_regs_test.sv
// self-checking bench for the touch status and error registers
`timescale 1ns/1ps
module tsr_regs_test;
	import tsr_pkg::*;
	logic clk_sys, rst, req_valid, req_write, req_unimpl, req_ro_hit;
	tsr_byte_t req_addr, req_wdata, rsp_rdata, eerr, ests, frame_count;
	tsr_byte_t fifo_count, fifo_wmrk;
	logic rsp_valid, rsp_refused, frame_end, touch, dual, fifo_full;
	logic attn_clr, attn_pin;
	int n_fail, checks_done, cycles;

	tsr_host_model u_tsr_host_model (.clk(clk_sys), .req_valid(req_valid),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.rsp_refused(rsp_refused));

	tsr_regs u_tsr_regs (.CLK_SYS(clk_sys), .RST(rst),
		.REQ_VALID(req_valid), .REQ_WRITE(req_write), .REQ_ADDR(req_addr),
		.REQ_WDATA(req_wdata), .REQ_UNIMPL(req_unimpl),
		.REQ_RO_HIT(req_ro_hit), .RSP_VALID(rsp_valid),
		.RSP_RDATA(rsp_rdata), .RSP_REFUSED(rsp_refused),
		.BAUD_FAIL(eerr[ERR_BAUD]), .FRAME_END(frame_end),
		.FRAME_COUNT(frame_count), .FRAME_TIMEOUT(eerr[ERR_EOF]),
		.PARITY_FAIL(eerr[ERR_PAR]), .CAL_FAIL(eerr[ERR_CAL]),
		.TOUCH_ACTIVE(touch), .DUAL_TOUCH_ACTIVE(dual),
		.ZOOM_EVT(ests[STS_ZOOM]), .ROTATE_EVT(ests[STS_ROT]),
		.SLIDE_EVT(ests[STS_SLIDE]), .FIFO_COUNT(fifo_count),
		.FIFO_WMRK(fifo_wmrk), .FIFO_FULL(fifo_full),
		.CAP_EVT(ests[STS_CAP]), .SAMPLE_DONE(ests[STS_RDY]),
		.HOST_ATTN_CLR(attn_clr), .HOST_ATTN_PIN(attn_pin));

	////////////////////////////////////////////////////////////////////////
	// clock and hang guard
	always #5 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 2000) begin
			n_fail++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// compare and report
	task automatic chk(input tsr_byte_t got, input tsr_byte_t exp,
		input string what);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what,
				got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// read a register and compare its data
	task automatic rd(input tsr_byte_t adr, input tsr_byte_t exp);
		tsr_byte_t d;
		logic rf, ok;
		u_tsr_host_model.xfer(1'b0, adr, 8'h00, d, rf, ok);
		chk({7'h00, ok}, 8'h01, "answer strobe");
		chk(d, exp, "read data");
	endtask

	// write a register and compare the refusal flag
	task automatic wr(input tsr_byte_t adr, input tsr_byte_t wd,
		input logic exp_rf);
		tsr_byte_t d;
		logic rf, ok;
		u_tsr_host_model.xfer(1'b1, adr, wd, d, rf, ok);
		chk({7'h00, ok}, 8'h01, "answer strobe");
		chk({7'h00, rf}, {7'h00, exp_rf}, "refusal flag");
	endtask

	// one-cycle event pulses on error and status sources
	task automatic pulse(input tsr_byte_t e, input tsr_byte_t s);
		@(posedge clk_sys);
		eerr <= e;
		ests <= s;
		@(posedge clk_sys);
		eerr <= 8'h00;
		ests <= 8'h00;
	endtask

	task automatic frame(input tsr_byte_t c);
		@(posedge clk_sys);
		frame_end <= 1'b1;
		frame_count <= c;
		@(posedge clk_sys);
		frame_end <= 1'b0;
	endtask

	task automatic live(input logic t, input logic d, input logic f,
		input tsr_byte_t c);
		@(posedge clk_sys);
		touch <= t;
		dual <= d;
		fifo_full <= f;
		fifo_count <= c;
	endtask

	////////////////////////////////////////////////////////////////////////
	// test sequence
	initial begin
		int srcs[4];
		tsr_byte_t vals[4];
		tsr_byte_t cnts[4];
		logic [3:0] bad;
		srcs = '{ERR_BAUD, ERR_CAL, ERR_EOF, ERR_PAR};
		vals = '{8'h04, 8'h05, 8'h64, 8'h65};
		cnts = '{8'h00, 8'h01, 8'h65, 8'h66};
		bad = 4'b1001;
		clk_sys = 1'b0;
		rst = 1'b1;
		{req_unimpl, req_ro_hit, frame_end, touch, dual} = 5'h00;
		{fifo_full, attn_clr} = 2'b00;
		{eerr, ests, frame_count, fifo_count} = 32'h0000_0000;
		fifo_wmrk = 8'h04;
		n_fail = 0;
		checks_done = 0;
		cycles = 0;
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		rd(ERR_REG_ADDR, ERR_RST);
		rd(STS_REG_ADDR, STS_RST);
		$display("test reset finished");
		for (int i = 0; i < 4; i++) begin
			pulse(8'h01 << srcs[i], 8'h00);
			rd(ERR_REG_ADDR, 8'h01 << srcs[i]);
			rd(ERR_REG_ADDR, 8'h00);
		end
		for (int i = 0; i < 4; i++) begin
			wr(SRATE_REG_ADDR, vals[i], 1'b0);
			rd(ERR_REG_ADDR, tsr_byte_t'(bad[i]) << ERR_SRATE);
			frame(cnts[i]);
			rd(ERR_REG_ADDR, tsr_byte_t'(bad[i]) << ERR_CNT);
		end
		$display("test error sources finished");
		wr(ERR_REG_ADDR, 8'hFF, 1'b1);
		rd(ERR_REG_ADDR, 8'h10);
		wr(STS_REG_ADDR, 8'hFF, 1'b1);
		rd(STS_REG_ADDR, 8'h00);
		rd(ERR_REG_ADDR, 8'h10);
		@(posedge clk_sys);
		req_ro_hit <= 1'b1;
		wr(8'h30, 8'h00, 1'b1);
		req_ro_hit <= 1'b0;
		rd(ERR_REG_ADDR, 8'h10);
		rd(8'h71, 8'h00);
		rd(ERR_REG_ADDR, 8'h04);
		rd(MAP_TOP_ADDR, 8'h00);
		rd(ERR_REG_ADDR, 8'h00);
		@(posedge clk_sys);
		req_unimpl <= 1'b1;
		rd(8'h40, 8'h00);
		req_unimpl <= 1'b0;
		rd(ERR_REG_ADDR, 8'h04);
		$display("test access faults finished");
		for (int b = 0; b < 8; b++) begin
			if (LATCH_MASK[b]) begin
				pulse(8'h00, 8'h01 << b);
				rd(STS_REG_ADDR, 8'h01 << b);
				rd(STS_REG_ADDR, 8'h00);
			end
		end
		live(1'b1, 1'b0, 1'b0, 8'h00);
		rd(STS_REG_ADDR, 8'h80);
		chk({7'h00, attn_pin}, 8'h01, "attention pin");
		live(1'b0, 1'b1, 1'b0, 8'h00);
		rd(STS_REG_ADDR, 8'h40);
		live(1'b0, 1'b0, 1'b0, 8'h03);
		rd(STS_REG_ADDR, 8'h00);
		live(1'b0, 1'b0, 1'b0, 8'h04);
		rd(STS_REG_ADDR, 8'h04);
		live(1'b0, 1'b0, 1'b1, 8'h00);
		rd(STS_REG_ADDR, 8'h04);
		live(1'b0, 1'b0, 1'b0, 8'h00);
		@(posedge clk_sys);
		attn_clr <= 1'b1;
		@(posedge clk_sys);
		attn_clr <= 1'b0;
		#1;
		chk({7'h00, attn_pin}, 8'h00, "attention cleared");
		$display("test status finished");
		fork
			rd(STS_REG_ADDR, 8'h00);
			pulse(8'h80, 8'h01);
		join
		rd(STS_REG_ADDR, 8'h01);
		chk({7'h00, attn_pin}, 8'h01, "attention set again");
		fork
			rd(ERR_REG_ADDR, 8'h80);
			pulse(8'h01, 8'h00);
		join
		rd(ERR_REG_ADDR, 8'h01);
		$display("test read collision finished");
		print_verdict();
	end
endmodule
